// ---- logic/vp_ingress_policy.v ----
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/1ps
`include "vp_defines.vh"
module vp_ingress_policy (
   // clock and reset
   input wire clk,
   input wire rst_n,
   // axi4-lite register bus
   input wire [11:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   output wire [1:0] s_axi_bresp,
   output wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire [11:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output wire [31:0] s_axi_rdata,
   output wire [1:0] s_axi_rresp,
   output wire s_axi_rvalid,
   input wire s_axi_rready,
   // received packet header, port 0..3 means port 1..4
   input wire in_valid,
   input wire [1:0] in_port,
   input wire in_tagged,
   input wire [11:0] in_vid,
   input wire [2:0] in_pri,
   input wire [4:0] in_member,
   // policy verdict
   output wire out_valid,
   output wire [1:0] out_port,
   output wire out_drop,
   output wire [2:0] out_pri,
   output wire [11:0] out_lookup_vid,
   output wire out_learn,
   // flow control per port, negotiated result in, applied state out
   input wire [3:0] an_rx_fc,
   input wire [3:0] an_tx_fc,
   output reg [3:0] fc_rx_en,
   output reg [3:0] fc_tx_en,
   // receive enable per port to the macs
   output reg [3:0] rx_enable,
   // egress tag request and answer
   input wire eg_valid,
   input wire [1:0] eg_port,
   output reg eg_tag_valid,
   output reg [15:0] eg_tag
);
   // per-port storage, port n in bits 8n+7..8n
   reg [31:0] pol_r;
   reg [31:0] tag_hi_r;
   reg [31:0] tag_lo_r;
   reg [31:0] pol_nxt;
   reg [31:0] tag_hi_nxt;
   reg [31:0] tag_lo_nxt;

   wire wr_stb;
   wire [7:0] wr_idx;
   wire [7:0] wr_data;
   wire [7:0] rd_idx;
   reg [7:0] rd_data;
   wire [4:0] wr_dec;
   wire [4:0] rd_dec;

   reg [7:0] sel_pol;
   reg [7:0] sel_hi;
   reg sel_member;
   integer i;
   integer j;

   // per-port fields unpacked from the register bytes
   reg [3:0] membership_drop_enable;
   reg [3:0] mismatched_default_vid_drop;
   reg [3:0] force_fc;
   reg [47:0] port_default_vlan_id;

   // index decode: {hit, kind, port}; kind 0 policy, 1 tag high, 2 tag low
   function [4:0] vp_decode;
      input [7:0] idx;
      reg hit_port;
      reg hit_kind;
      reg [1:0] port;
      reg [1:0] kind;
      begin
         hit_port = 1'b1;
         hit_kind = 1'b1;
         case (idx[7:4])
            4'h1: port = 2'd0;
            4'h2: port = 2'd1;
            4'h3: port = 2'd2;
            4'h5: port = 2'd3;
            default: begin
               port = 2'd0;
               hit_port = 1'b0;
            end
         endcase
         case (idx[3:0])
            `VP_KIND_POLICY: kind = 2'd0;
            `VP_KIND_TAG_HI: kind = 2'd1;
            `VP_KIND_TAG_LO: kind = 2'd2;
            default: begin
               kind = 2'd0;
               hit_kind = 1'b0;
            end
         endcase
         vp_decode = {hit_port & hit_kind, kind, port};
      end
   endfunction

   // byte of a packed per-port vector
   function [7:0] vp_byte;
      input [31:0] vec;
      input [1:0] port;
      begin
         vp_byte = vec[port*8 +: 8];
      end
   endfunction

   // membership bit of a port in the VLAN table vector
   function vp_member_bit;
      input [4:0] mbr;
      input [1:0] port;
      begin
         case (port)
            2'd0: vp_member_bit = mbr[`VP_MBR_P1];
            2'd1: vp_member_bit = mbr[`VP_MBR_P2];
            2'd2: vp_member_bit = mbr[`VP_MBR_P3];
            default: vp_member_bit = mbr[`VP_MBR_P4];
         endcase
      end
   endfunction

   // flag of one port from a per-port flag vector
   function vp_port_flag;
      input [3:0] flags;
      input [1:0] port;
      begin
         vp_port_flag = flags[port];
      end
   endfunction

   // default VLAN id of one port from the packed id vector
   function [11:0] vp_port_vid;
      input [47:0] vids;
      input [1:0] port;
      begin
         vp_port_vid = vids[port*12 +: 12];
      end
   endfunction

   // flow control of one direction: forced on, else the negotiated result
   function [3:0] vp_fc_merge;
      input [3:0] forced;
      input [3:0] negotiated;
      begin
         vp_fc_merge = forced | negotiated;
      end
   endfunction

   assign wr_dec = vp_decode(wr_idx);
   assign rd_dec = vp_decode(rd_idx);

   // bus slave
   vp_axil_slave u_bus (
      .clk(clk),
      .rst_n(rst_n),
      .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready),
      .wr_stb(wr_stb),
      .wr_idx(wr_idx),
      .wr_data(wr_data),
      .wr_ok(wr_dec[4]),
      .rd_idx(rd_idx),
      .rd_data(rd_data),
      .rd_ok(rd_dec[4])
   );

   // register write: only the addressed port's copy changes
   always @* begin
      pol_nxt = pol_r;
      tag_hi_nxt = tag_hi_r;
      tag_lo_nxt = tag_lo_r;
      if (wr_stb && wr_dec[4]) begin
         case (wr_dec[3:2])
            2'd0: pol_nxt[wr_dec[1:0]*8 +: 8] = wr_data;
            2'd1: tag_hi_nxt[wr_dec[1:0]*8 +: 8] = wr_data;
            default: tag_lo_nxt[wr_dec[1:0]*8 +: 8] = wr_data;
         endcase
      end
   end

   // register state with reset values, receive enable on, learning on
   always @(posedge clk) begin
      if (!rst_n) begin
         pol_r <= {4{`VP_RST_POLICY}};
         tag_hi_r <= {4{`VP_RST_TAG_HI}};
         tag_lo_r <= {4{`VP_RST_TAG_LO}};
      end else begin
         pol_r <= pol_nxt;
         tag_hi_r <= tag_hi_nxt;
         tag_lo_r <= tag_lo_nxt;
      end
   end

   // register read mux, unmapped reads return zero
   always @* begin
      rd_data = 8'h00;
      if (rd_dec[4]) begin
         case (rd_dec[3:2])
            2'd0: rd_data = vp_byte(pol_r, rd_dec[1:0]);
            2'd1: rd_data = vp_byte(tag_hi_r, rd_dec[1:0]);
            default: rd_data = vp_byte(tag_lo_r, rd_dec[1:0]);
         endcase
      end
   end

   // unpack drop enables, forced flow control and default ids of every port
   always @* begin
      membership_drop_enable = 4'h0;
      mismatched_default_vid_drop = 4'h0;
      force_fc = 4'h0;
      port_default_vlan_id = 48'h000000000000;
      for (j = 0; j < 4; j = j + 1) begin
         membership_drop_enable[j] = pol_r[j*8 + `VP_POL_FILT];
         mismatched_default_vid_drop[j] = pol_r[j*8 + `VP_POL_MISMATCH];
         force_fc[j] = pol_r[j*8 + `VP_POL_FORCE_FC];
         port_default_vlan_id[j*12 +: 12] = {tag_hi_r[j*8 +: 4], tag_lo_r[j*8 +: 8]};
      end
   end

   // settings of the port the packet arrived on
   always @* begin
      sel_pol = vp_byte(pol_r, in_port);
      sel_hi = vp_byte(tag_hi_r, in_port);
      sel_member = vp_member_bit(in_member, in_port);
   end

   // packet verdict
   vp_pkt_policy u_pkt (
      .clk(clk),
      .rst_n(rst_n),
      .in_valid(in_valid),
      .in_port(in_port),
      .in_tagged(in_tagged),
      .in_vid(in_vid),
      .in_pri(in_pri),
      .in_member(sel_member),
      .ceil_en(sel_pol[`VP_POL_CEIL]),
      .filt_en(vp_port_flag(membership_drop_enable, in_port)),
      .mismatch_en(vp_port_flag(mismatched_default_vid_drop, in_port)),
      .rx_en(sel_pol[`VP_POL_RX_EN]),
      .learn_dis(sel_pol[`VP_POL_LEARN_DIS]),
      .def_pri(sel_hi[7:5]),
      .def_vid(vp_port_vid(port_default_vlan_id, in_port)),
      .out_valid(out_valid),
      .out_port(out_port),
      .out_drop(out_drop),
      .out_pri(out_pri),
      .out_lookup_vid(out_lookup_vid),
      .out_learn(out_learn)
   );

   // per-port flow control and receive enable outputs
   always @(posedge clk) begin
      if (!rst_n) begin
         fc_rx_en <= 4'h0;
         fc_tx_en <= 4'h0;
         rx_enable <= 4'hf;
      end else begin
         fc_rx_en <= vp_fc_merge(force_fc, an_rx_fc);
         fc_tx_en <= vp_fc_merge(force_fc, an_tx_fc);
         for (i = 0; i < 4; i = i + 1) begin
            rx_enable[i] <= pol_r[i*8 + `VP_POL_RX_EN];
         end
      end
   end

   // egress tag built from the port default tag
   always @(posedge clk) begin
      if (!rst_n) begin
         eg_tag_valid <= 1'b0;
         eg_tag <= 16'h0000;
      end else begin
         eg_tag_valid <= eg_valid;
         if (eg_valid) begin
            eg_tag <= {vp_byte(tag_hi_r, eg_port), vp_byte(tag_lo_r, eg_port)};
         end
      end
   end
endmodule

// ---- logic/vp_defines.vh ----
// Functional notes
// - ceiling on: packet priority above default tag priority is replaced by it.
// - membership filter on: drop packets whose VID membership lacks the ingress port.
// - mismatch drop on: drop packets whose VID differs from port default VID.
// - forced flow control on: rx and tx flow control on, ignoring negotiation.
// - packets accepted only while receive enable is 1; resets to 1.
// - addresses learned only while learning disable is 0; resets to 0.
// - tag high byte holds priority 7:5, CFI 4, VID 11:8 in 3:0.
// - tag low byte holds VID 7:0; resets to 0x01.
// - default VID used for egress tagging and untagged or null-VID lookup.
`ifndef VP_DEFINES_VH
`define VP_DEFINES_VH

// register indices, byte address is four times the index
`define VP_IDX_P1_POLICY 8'h12
`define VP_IDX_P1_TAG_HI 8'h13
`define VP_IDX_P1_TAG_LO 8'h14
`define VP_IDX_P2_POLICY 8'h22
`define VP_IDX_P2_TAG_HI 8'h23
`define VP_IDX_P2_TAG_LO 8'h24
`define VP_IDX_P3_POLICY 8'h32
`define VP_IDX_P3_TAG_HI 8'h33
`define VP_IDX_P3_TAG_LO 8'h34
`define VP_IDX_P4_POLICY 8'h52
`define VP_IDX_P4_TAG_HI 8'h53
`define VP_IDX_P4_TAG_LO 8'h54
// low nibble of an index selects the register kind
`define VP_KIND_POLICY 4'h2
`define VP_KIND_TAG_HI 4'h3
`define VP_KIND_TAG_LO 4'h4

// ingress policy byte fields
`define VP_POL_CEIL 7
`define VP_POL_FILT 6
`define VP_POL_MISMATCH 5
`define VP_POL_FORCE_FC 4
`define VP_POL_RX_EN 1
`define VP_POL_LEARN_DIS 0

// reset values
`define VP_RST_POLICY 8'h02
`define VP_RST_TAG_HI 8'h00
`define VP_RST_TAG_LO 8'h01

// membership vector bit of each port (bit 3 unused)
`define VP_MBR_P1 0
`define VP_MBR_P2 1
`define VP_MBR_P3 2
`define VP_MBR_P4 4

// axi responses
`define VP_RESP_OKAY 2'b00
`define VP_RESP_SLVERR 2'b10

`endif

// ---- logic/vp_axil_slave.v ----
`timescale 1ns/1ps
`include "vp_defines.vh"
module vp_axil_slave (
   // clock and reset
   input wire clk,
   input wire rst_n,
   // axi4-lite slave
   input wire [11:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [11:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // register side
   output wire wr_stb,
   output wire [7:0] wr_idx,
   output wire [7:0] wr_data,
   input wire wr_ok,
   output wire [7:0] rd_idx,
   input wire [7:0] rd_data,
   input wire rd_ok
);
   reg aw_held_r;
   reg w_held_r;
   reg [7:0] aw_idx_r;
   reg [7:0] w_data_r;
   reg w_lane_r;
   reg rd_pend_r;
   reg [7:0] ar_idx_r;

   assign wr_stb = aw_held_r & w_held_r & ~s_axi_bvalid & w_lane_r;
   assign wr_idx = aw_idx_r;
   assign wr_data = w_data_r;
   assign rd_idx = ar_idx_r;

   // write path: address and data taken in either order, then one response
   always @(posedge clk) begin
      if (!rst_n) begin
         aw_held_r <= 1'b0;
         w_held_r <= 1'b0;
         aw_idx_r <= 8'h00;
         w_data_r <= 8'h00;
         w_lane_r <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `VP_RESP_OKAY;
      end else begin
         s_axi_awready <= ~aw_held_r & ~s_axi_awready & ~s_axi_bvalid;
         s_axi_wready <= ~w_held_r & ~s_axi_wready & ~s_axi_bvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_r <= 1'b1;
            aw_idx_r <= s_axi_awaddr[9:2];
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_r <= 1'b1;
            w_data_r <= s_axi_wdata[7:0];
            w_lane_r <= s_axi_wstrb[0]; // only the low lane carries data
         end
         if (aw_held_r && w_held_r && !s_axi_bvalid) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? `VP_RESP_OKAY : `VP_RESP_SLVERR;
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // read path: address taken, data one cycle later from the index
   always @(posedge clk) begin
      if (!rst_n) begin
         s_axi_arready <= 1'b0;
         rd_pend_r <= 1'b0;
         ar_idx_r <= 8'h00;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `VP_RESP_OKAY;
      end else begin
         s_axi_arready <= ~s_axi_arready & ~rd_pend_r & ~s_axi_rvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            rd_pend_r <= 1'b1;
            ar_idx_r <= s_axi_araddr[9:2];
         end
         if (rd_pend_r) begin
            rd_pend_r <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h000000, rd_data};
            s_axi_rresp <= rd_ok ? `VP_RESP_OKAY : `VP_RESP_SLVERR;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule

// ---- logic/vp_pkt_policy.v ----
`timescale 1ns/1ps
module vp_pkt_policy (
   // clock and reset
   input wire clk,
   input wire rst_n,
   // packet header from the receive mac
   input wire in_valid,
   input wire [1:0] in_port,
   input wire in_tagged,
   input wire [11:0] in_vid,
   input wire [2:0] in_pri,
   input wire in_member,
   // settings of the ingress port
   input wire ceil_en,
   input wire filt_en,
   input wire mismatch_en,
   input wire rx_en,
   input wire learn_dis,
   input wire [2:0] def_pri,
   input wire [11:0] def_vid,
   // verdict to the forwarding engine
   output reg out_valid,
   output reg [1:0] out_port,
   output reg out_drop,
   output reg [2:0] out_pri,
   output reg [11:0] out_lookup_vid,
   output reg out_learn
);
   wire null_vid;
   wire [11:0] eff_vid;
   wire drop;

   // untagged or null-VID packets take the port default VID
   assign null_vid = ~in_tagged | (in_vid == 12'h000);
   assign eff_vid = null_vid ? def_vid : in_vid;
   // receive gate, membership filter and default VID mismatch
   assign drop = ~rx_en | (filt_en & ~in_member) | (mismatch_en & (eff_vid != def_vid));

   // one-cycle verdict register
   always @(posedge clk) begin
      if (!rst_n) begin
         out_valid <= 1'b0;
         out_port <= 2'b00;
         out_drop <= 1'b0;
         out_pri <= 3'b000;
         out_lookup_vid <= 12'h000;
         out_learn <= 1'b0;
      end else begin
         out_valid <= in_valid;
         if (in_valid) begin
            out_port <= in_port;
            out_drop <= drop;
            out_pri <= (ceil_en && (in_pri > def_pri)) ? def_pri : in_pri;
            out_lookup_vid <= eff_vid;
            out_learn <= ~learn_dis & ~drop;
         end
      end
   end
endmodule

// ---- test/vp_ingress_policy_monitor.sv ----
`timescale 1ns/1ps
module vp_ingress_policy_monitor (
   // clock and reset
   input wire clk,
   input wire rst_n,
   // packet path
   input wire in_valid,
   input wire in_tagged,
   input wire [11:0] in_vid,
   input wire [2:0] in_pri,
   input wire out_valid,
   input wire out_drop,
   input wire [2:0] out_pri,
   input wire [11:0] out_lookup_vid,
   input wire out_learn,
   // flow control, receive enable, egress
   input wire [3:0] an_rx_fc,
   input wire [3:0] an_tx_fc,
   input wire [3:0] fc_rx_en,
   input wire [3:0] fc_tx_en,
   input wire [3:0] rx_enable,
   input wire eg_valid,
   input wire eg_tag_valid,
   // register bus answers
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire s_axi_rvalid,
   input wire s_axi_rready
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // header taken, verdict one cycle later
   sequence s_pkt;
      in_valid ##1 out_valid;
   endsequence
   sequence s_tagged_pkt;
      in_valid && in_tagged && in_vid != 12'h000 ##1 out_valid;
   endsequence
   chk_verdict_one_cycle: assert property (in_valid |=> out_valid)
      else $error("verdict missing one cycle after header");
   chk_verdict_cause: assert property (out_valid |-> $past(in_valid))
      else $error("verdict without header");
   chk_pri_never_raised: assert property (s_pkt |-> out_pri <= $past(in_pri))
      else $error("priority raised above packet priority");
   chk_tagged_lookup_vid: assert property (s_tagged_pkt |-> out_lookup_vid == $past(in_vid))
      else $error("tagged packet lookup vid altered");
   chk_drop_no_learn: assert property (out_valid && out_drop |-> !out_learn)
      else $error("dropped packet learned");
   chk_rx_fc_follow: assert property ($past(rst_n) |-> (fc_rx_en & $past(an_rx_fc)) == $past(an_rx_fc))
      else $error("rx flow control below negotiated result");
   chk_tx_fc_follow: assert property ($past(rst_n) |-> (fc_tx_en & $past(an_tx_fc)) == $past(an_tx_fc))
      else $error("tx flow control below negotiated result");
   chk_rx_en_reset: assert property ($rose(rst_n) |-> rx_enable == 4'hf)
      else $error("receive enable not set after reset");
   chk_egress_answer: assert property (eg_valid |=> eg_tag_valid)
      else $error("egress tag answer missing");
   chk_bresp_retire: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response not retired after handshake");
   chk_rresp_retire: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read response not retired after handshake");
endmodule

bind vp_ingress_policy vp_ingress_policy_monitor mon_u (.clk, .rst_n, .in_valid, .in_tagged,
   .in_vid, .in_pri, .out_valid, .out_drop, .out_pri, .out_lookup_vid, .out_learn, .an_rx_fc,
   .an_tx_fc, .fc_rx_en, .fc_tx_en, .rx_enable, .eg_valid, .eg_tag_valid, .s_axi_bvalid,
   .s_axi_bready, .s_axi_rvalid, .s_axi_rready);

// ---- test/vp_mac_model.sv ----
`timescale 1ns/1ps
module vp_mac_model (
   // clock
   input wire clk,
   // header towards the policy block
   output reg in_valid,
   output reg [1:0] in_port,
   output reg in_tagged,
   output reg [11:0] in_vid,
   output reg [2:0] in_pri,
   output reg [4:0] in_member
);
   // idle at time zero
   initial begin
      {in_valid, in_port, in_tagged, in_vid, in_pri, in_member} = 24'h0;
   end
   // one header per call, fields other than the port scrambled once released
   task send(input [1:0] pt, input tg, input [11:0] v, input [2:0] pr, input [4:0] m);
      @(posedge clk);
      {in_valid, in_port, in_tagged, in_vid, in_pri, in_member} <= {1'b1, pt, tg, v, pr, m};
      @(posedge clk);
      {in_valid, in_tagged, in_vid, in_pri, in_member} <= {1'b0, ~tg, ~v, ~pr, ~m};
   endtask
endmodule

// ---- test/test_vp_ingress_policy.sv ----
`timescale 1ns/1ps
`include "vp_defines.vh"
module test_vp_ingress_policy;
   reg clk = 1'b0;
   reg rst_n = 1'b0;
   // register bus master side
   reg [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
   reg [31:0] s_axi_wdata = 32'h0;
   reg [3:0] s_axi_wstrb = 4'hf;
   reg s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   reg s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   // packet path
   wire in_valid, in_tagged, out_valid, out_drop, out_learn;
   wire [1:0] in_port, out_port;
   wire [11:0] in_vid, out_lookup_vid;
   wire [2:0] in_pri, out_pri;
   wire [4:0] in_member;
   // flow control and egress
   reg [3:0] an_rx_fc = 4'h0, an_tx_fc = 4'h0;
   wire [3:0] fc_rx_en, fc_tx_en, rx_enable;
   reg eg_valid = 1'b0;
   reg [1:0] eg_port = 2'd0;
   wire eg_tag_valid;
   wire [15:0] eg_tag;
   integer n_errors = 0, num_checks = 0, cyc = 0, p;

   vp_ingress_policy dut_u (.clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .in_valid, .in_port, .in_tagged, .in_vid, .in_pri,
      .in_member, .out_valid, .out_port, .out_drop, .out_pri, .out_lookup_vid, .out_learn,
      .an_rx_fc, .an_tx_fc, .fc_rx_en, .fc_tx_en, .rx_enable, .eg_valid, .eg_port,
      .eg_tag_valid, .eg_tag);
   vp_mac_model mac_u (.clk, .in_valid, .in_port, .in_tagged, .in_vid, .in_pri, .in_member);

   // clock
   initial begin
      forever #5 clk = ~clk;
   end
   // compare and count
   task chk(input [31:0] got, input [31:0] exp);
      num_checks = num_checks + 1;
      if (got !== exp) begin
         n_errors = n_errors + 1;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // byte address of a port register
   function [11:0] ra(input integer port, input [3:0] kind);
      ra = {2'b00, (port == 3 ? 4'h5 : port[3:0] + 4'h1), kind, 2'b00};
   endfunction
   // axi write, both channels offered together
   task wr(input [11:0] a, input [7:0] d, input [1:0] er);
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
      do begin
         @(posedge clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      chk(s_axi_bresp, er);
   endtask
   // axi read with expected byte
   task rdc(input [11:0] a, input [7:0] exp, input [1:0] er);
      @(posedge clk);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'b11;
      do begin
         @(posedge clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      chk(s_axi_rdata, {24'h0, exp});
      chk(s_axi_rresp, er);
   endtask
   // one header and its verdict
   task pkt(input [1:0] pt, input tg, input [11:0] v, input [2:0] pr, input [4:0] m,
      input dr, input [2:0] opr, input [11:0] lv, input ln);
      mac_u.send(pt, tg, v, pr, m);
      #1;
      chk({out_valid, out_port, out_drop, out_learn}, {1'b1, pt, dr, ln});
      chk(out_pri, opr);
      chk(out_lookup_vid, lv);
   endtask
   // egress tag request
   task egc(input [1:0] pt, input [15:0] exp);
      @(posedge clk);
      eg_valid <= 1'b1;
      eg_port <= pt;
      @(posedge clk);
      eg_valid <= 1'b0;
      #1;
      chk(eg_tag_valid, 1'b1);
      chk(eg_tag, exp);
   endtask
   task stop_test;
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // hang guard
   always @(posedge clk) begin
      cyc = cyc + 1;
      if (cyc == 20000) begin
         n_errors = n_errors + 1;
         stop_test;
      end
   end
   // main sequence
   initial begin
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
      for (p = 0; p < 4; p = p + 1) begin
         rdc(ra(p, `VP_KIND_POLICY), `VP_RST_POLICY, `VP_RESP_OKAY);
         rdc(ra(p, `VP_KIND_TAG_HI), 8'h00, `VP_RESP_OKAY);
         rdc(ra(p, `VP_KIND_TAG_LO), 8'h01, `VP_RESP_OKAY);
      end
      chk(rx_enable, 4'hf);
      wr(12'h108, 8'h5a, `VP_RESP_SLVERR);
      rdc(12'h108, 8'h00, `VP_RESP_SLVERR);
      s_axi_wstrb <= 4'he;
      wr(ra(1, `VP_KIND_TAG_LO), 8'h33, `VP_RESP_OKAY);
      s_axi_wstrb <= 4'hf;
      rdc(ra(1, `VP_KIND_TAG_LO), 8'h01, `VP_RESP_OKAY);
      wr(ra(2, `VP_KIND_TAG_HI), 8'h75, `VP_RESP_OKAY);
      wr(ra(2, `VP_KIND_TAG_LO), 8'ha6, `VP_RESP_OKAY);
      rdc(ra(2, `VP_KIND_TAG_HI), 8'h75, `VP_RESP_OKAY);
      egc(2'd2, 16'h75a6);
      egc(2'd0, 16'h0001);
      wr(ra(2, `VP_KIND_POLICY), 8'ha2, `VP_RESP_OKAY);
      pkt(2'd2, 1'b1, 12'h5a6, 3'd5, 5'h1f, 1'b0, 3'd3, 12'h5a6, 1'b1);
      pkt(2'd2, 1'b1, 12'h5a6, 3'd2, 5'h1f, 1'b0, 3'd2, 12'h5a6, 1'b1);
      pkt(2'd2, 1'b1, 12'h123, 3'd2, 5'h1f, 1'b1, 3'd2, 12'h123, 1'b0);
      pkt(2'd2, 1'b0, 12'h123, 3'd2, 5'h1f, 1'b0, 3'd2, 12'h5a6, 1'b1);
      pkt(2'd2, 1'b1, 12'h000, 3'd2, 5'h1f, 1'b0, 3'd2, 12'h5a6, 1'b1);
      pkt(2'd0, 1'b1, 12'h123, 3'd5, 5'h1f, 1'b0, 3'd5, 12'h123, 1'b1);
      wr(ra(2, `VP_KIND_POLICY), 8'h42, `VP_RESP_OKAY);
      pkt(2'd2, 1'b1, 12'h5a6, 3'd1, 5'h1b, 1'b1, 3'd1, 12'h5a6, 1'b0);
      pkt(2'd2, 1'b1, 12'h5a6, 3'd1, 5'h04, 1'b0, 3'd1, 12'h5a6, 1'b1);
      wr(ra(3, `VP_KIND_POLICY), 8'h42, `VP_RESP_OKAY);
      pkt(2'd3, 1'b1, 12'h777, 3'd0, 5'h10, 1'b0, 3'd0, 12'h777, 1'b1);
      pkt(2'd3, 1'b1, 12'h777, 3'd0, 5'h0f, 1'b1, 3'd0, 12'h777, 1'b0);
      wr(ra(2, `VP_KIND_POLICY), 8'h03, `VP_RESP_OKAY);
      pkt(2'd2, 1'b1, 12'h5a6, 3'd1, 5'h1f, 1'b0, 3'd1, 12'h5a6, 1'b0);
      wr(ra(2, `VP_KIND_POLICY), 8'h00, `VP_RESP_OKAY);
      pkt(2'd2, 1'b1, 12'h5a6, 3'd1, 5'h1f, 1'b1, 3'd1, 12'h5a6, 1'b0);
      chk(rx_enable, 4'hb);
      wr(ra(2, `VP_KIND_POLICY), 8'h12, `VP_RESP_OKAY);
      @(posedge clk);
      #1;
      chk({fc_rx_en, fc_tx_en}, 8'h44);
      wr(ra(2, `VP_KIND_POLICY), 8'h02, `VP_RESP_OKAY);
      an_rx_fc <= 4'hb;
      an_tx_fc <= 4'h1;
      repeat (2) @(posedge clk);
      #1;
      chk({fc_rx_en, fc_tx_en}, 8'hb1);
      stop_test;
   end
endmodule
